// file: design/trigger_key_defs.vh
// constants for the trigger and key input control block
`ifndef TRIGGER_KEY_DEFS_VH
`define TRIGGER_KEY_DEFS_VH

// clock rate in kHz
`define CLK_KHZ          20000
// trigger pulse limits in ms
`define TRIG_MIN_MS      150
`define TRIG_MAX_MS      10000
// key press limits in ms
`define KEY_BRIEF_MS     200
`define KEY_LONG_MS      3000
// flashing decimal point half period in ms
`define BLINK_MS         500
// derived cycle counts
`define TRIG_MIN_CYC     (`TRIG_MIN_MS * `CLK_KHZ)
`define TRIG_MAX_CYC     (`TRIG_MAX_MS * `CLK_KHZ)
`define KEY_BRIEF_CYC    (`KEY_BRIEF_MS * `CLK_KHZ)
`define KEY_LONG_CYC     (`KEY_LONG_MS * `CLK_KHZ)
`define BLINK_CYC        (`BLINK_MS * `CLK_KHZ)

// register offsets
`define REG_CTRL         4'h0
`define REG_STATUS       4'h1
`define REG_LIMIT1       4'h2
`define REG_LIMIT2       4'h3
`define REG_AOUT_LO      4'h4
`define REG_AOUT_HI      4'h5
`define REG_KEYS         4'h6
`define REG_VALUE        4'h7

// control register fields
`define CTRL_ACT_LSB     0
`define CTRL_ACT_MSB     1
`define CTRL_REL1_POL    2
`define CTRL_REL2_POL    3
`define CTRL_AOUT_MAX    4
`define CTRL_SHOW_MAX    5
`define CTRL_RESET       16'h0000

// trigger actions
`define ACT_NONE         2'h0
`define ACT_TARE         2'h1
`define ACT_PEAK         2'h2
`define ACT_BOTH         2'h3

// status register fields
`define ST_TRIG          0
`define ST_NET           1
`define ST_SETUP         2
`define ST_LIM1          3
`define ST_LIM2          4
`define ST_SHOW_MAX      5

// telegram status layout
`define TG_HEADER        2'h3

`endif

// file: design/sync_timer.v
// two-flop synchroniser with a high-time counter and pulse qualifier
`timescale 1ns/1ps
module sync_timer #(
	parameter CW     = 28,
	parameter MIN_C  = 3000000,
	parameter MAX_C  = 200000000,
	parameter INVERT = 0
) (
	// clock and reset
	input  wire          clk_i,
	input  wire          nrst_i,
	// raw pin
	input  wire          pin_i,
	// synchronised active level and events
	output reg           level_o,
	output reg           short_o,
	output reg           long_o,
	output reg           valid_o
);
	reg          meta;
	reg          sync;
	reg [CW-1:0] cnt;
	reg          min_seen;
	reg          max_seen;
	wire         act;

	assign act = INVERT ? ~sync : sync;

	always @(posedge clk_i) begin
		if (!nrst_i) begin
			meta     <= 1'b0;
			sync     <= 1'b0;
			level_o  <= 1'b0;
			cnt      <= {CW{1'b0}};
			min_seen <= 1'b0;
			max_seen <= 1'b0;
			short_o  <= 1'b0;
			long_o   <= 1'b0;
			valid_o  <= 1'b0;
		end else begin
			meta    <= pin_i;
			sync    <= meta;
			level_o <= act;
			short_o <= 1'b0;
			long_o  <= 1'b0;
			valid_o <= 1'b0;
			if (act) begin
				if (!max_seen)
					cnt <= cnt + {{(CW-1){1'b0}}, 1'b1};
				if (cnt == MIN_C[CW-1:0] - {{(CW-1){1'b0}}, 1'b1}) begin
					min_seen <= 1'b1;
					short_o  <= 1'b1;
				end
				// the counter parks one count past the limit, so flag it only once
				if (cnt == MAX_C[CW-1:0] && !max_seen) begin
					max_seen <= 1'b1;
					long_o   <= 1'b1;
				end
			end else begin
				// falling edge qualifies the pulse once
				if (level_o && min_seen && !max_seen)
					valid_o <= 1'b1;
				cnt      <= {CW{1'b0}};
				min_seen <= 1'b0;
				max_seen <= 1'b0;
			end
		end
	end
endmodule

// file: design/key_input.v
// external key reader: brief and long press classification
`timescale 1ns/1ps
`include "trigger_key_defs.vh"
module key_input #(
	parameter NKEY    = 3,
	parameter BRIEF_C = 4000000,
	parameter LONG_C  = 60000000
) (
	// clock and reset
	input  wire            clk_i,
	input  wire            nrst_i,
	// active-low key pins, open reads high
	input  wire [NKEY-1:0] key_n_i,
	// pressed level and press events
	output wire [NKEY-1:0] held_o,
	output wire [NKEY-1:0] brief_o,
	output wire [NKEY-1:0] long_o
);
	genvar k;
	generate
		for (k = 0; k < NKEY; k = k + 1) begin : g_key
			sync_timer #(
				.CW     (28),
				.MIN_C  (BRIEF_C),
				.MAX_C  (LONG_C),
				.INVERT (1)
			) u_tim (
				.clk_i   (clk_i),
				.nrst_i  (nrst_i),
				.pin_i   (key_n_i[k]),
				.level_o (held_o[k]),
				.short_o (brief_o[k]),
				.long_o  (long_o[k]),
				.valid_o ()
			);
		end
	endgenerate
endmodule

// file: design/trigger_key_control.v
// trigger dispatch, key input, limit indicators and display marks
//
// Operation
// (R1) every telegram carries the present trigger level as status bit
// (R2) four stored trigger actions: none, tare, peak reset, both
// (R3) tare action zeroes the value and selects net indication
// (R4) peak action reloads the maximum from the instantaneous value
// (R5) combined action tares and reloads the maximum on one pulse
// (R6) actions start only on a high-going trigger pulse
// (R7) the far side holds each pulse high 150 ms to 10 s
// (R8) the action runs whether value or maximum is displayed
// (R9) an open trigger input reads low
// (R10) limit LEDs light while their limit is exceeded
// (R11) stored per-relay choice of closing or opening on a limit
// (R12) external keys act parallel to front keys, pressed when low
// (R13) an open key input reads high, key released
// (R14) setup and calibration entry only while the strap is grounded
// (R15) strap open locks out setup and calibration
// (R16) analog span maps a chosen range; follows value or maximum
// (R17) maximum indication shows a flashing right-hand decimal point
// (R18) leading zero digits are blanked on value indication
// (R19) presses of 0.2 s are brief, 3 s long; brief runs first
// (R20) trigger is synchronised; too short or too long pulses ignored
// (R21) one action per qualifying pulse, not repeated while high
`timescale 1ns/1ps
`include "trigger_key_defs.vh"
module trigger_key_control #(
	parameter TRIG_MIN_C  = `TRIG_MIN_CYC,
	parameter TRIG_MAX_C  = `TRIG_MAX_CYC,
	parameter KEY_BRIEF_C = `KEY_BRIEF_CYC,
	parameter KEY_LONG_C  = `KEY_LONG_CYC,
	parameter BLINK_C     = `BLINK_CYC,
	parameter VW          = 14
) (
	// clock and reset
	input  wire          clk_i,
	input  wire          nrst_i,
	// register port
	input  wire [3:0]    addr_i,
	input  wire [15:0]   wdata_i,
	input  wire          wr_i,
	input  wire          rd_i,
	output reg  [15:0]   rdata_o,
	// pins from the outside world
	input  wire          trig_i,
	input  wire [2:0]    key_n_i,
	input  wire          setup_n_i,
	// measurement side
	input  wire [VW-1:0] value_i,
	input  wire          sample_i,
	// telegram first byte
	output reg  [7:0]    tg_byte_o,
	output reg           tg_valid_o,
	// actions to the measurement core
	output reg           tare_o,
	output reg           peak_reset_o,
	// indicators
	output reg           led1_o,
	output reg           led2_o,
	output reg           relay1_o,
	output reg           relay2_o,
	output reg           net_o,
	output reg           dp_o,
	output reg  [3:0]    digit_blank_o,
	output reg  [VW-1:0] aout_o,
	// key events and setup gate
	output reg  [2:0]    key_brief_o,
	output reg  [2:0]    key_long_o,
	output reg           setup_ok_o
);
	// stored settings
	reg  [15:0]   ctrl;
	reg  [VW-1:0] limit1;
	reg  [VW-1:0] limit2;
	reg  [VW-1:0] aout_lo;
	reg  [VW-1:0] aout_hi;
	// working state
	reg  [VW-1:0] peak;
	reg  [VW-1:0] tare_val;
	reg           net;
	reg           setup_meta;
	reg           setup_sync;
	reg  [27:0]   blink_cnt;
	reg           blink;
	reg  [VW-1:0] next_aout;
	reg  [VW-1:0] src;
	reg  [VW-1:0] net_val;
	wire          trig_lvl;
	wire          trig_valid;
	wire [2:0]    held;
	wire [2:0]    brief;
	wire [2:0]    long_p;
	wire [1:0]    act;
	wire          do_tare;
	wire          do_peak;
	wire          lim1;
	wire          lim2;
	wire          setup_ok;

	// blanking mask for a four-digit decimal indication
	function [3:0] blank_mask;
		input [VW-1:0] v;
		begin
			if (v >= 14'd1000)
				blank_mask = 4'h0;
			else if (v >= 14'd100)
				blank_mask = 4'h8;
			else if (v >= 14'd10)
				blank_mask = 4'hC;
			else
				blank_mask = 4'hE;
		end
	endfunction

	// trigger pin: low when open, timed after two flops
	sync_timer #(
		.CW     (28),
		.MIN_C  (TRIG_MIN_C),
		.MAX_C  (TRIG_MAX_C),
		.INVERT (0)
	) u_trig (
		.clk_i   (clk_i),
		.nrst_i  (nrst_i),
		.pin_i   (trig_i),            // [R9] [R20]
		.level_o (trig_lvl),
		.short_o (),
		.long_o  (),
		.valid_o (trig_valid)         // [R6] [R21]
	);

	key_input #(
		.NKEY    (3),
		.BRIEF_C (KEY_BRIEF_C),
		.LONG_C  (KEY_LONG_C)
	) u_keys (
		.clk_i   (clk_i),
		.nrst_i  (nrst_i),
		.key_n_i (key_n_i),           // [R12] [R13]
		.held_o  (held),
		.brief_o (brief),             // [R19]
		.long_o  (long_p)             // [R19]
	);

	assign act      = ctrl[`CTRL_ACT_MSB:`CTRL_ACT_LSB];
	// display mode is not consulted here
	assign do_tare  = trig_valid &&
		(act == `ACT_TARE || act == `ACT_BOTH);    // [R3] [R5] [R8]
	assign do_peak  = trig_valid &&
		(act == `ACT_PEAK || act == `ACT_BOTH);    // [R4] [R5] [R8]
	assign lim1     = ($signed({1'b0, net_val}) > $signed({1'b0, limit1}));
	assign lim2     = ($signed({1'b0, net_val}) > $signed({1'b0, limit2}));
	assign setup_ok = ~setup_sync;                 // [R14] [R15]

	always @* begin
		net_val = net ? (value_i - tare_val) : value_i;
		src     = ctrl[`CTRL_AOUT_MAX] ? peak : net_val;   // [R16]
		if (src <= aout_lo)
			next_aout = {VW{1'b0}};
		else if (src >= aout_hi)
			next_aout = aout_hi - aout_lo;
		else
			next_aout = src - aout_lo;                 // [R16]
	end

	// register writes and persistent settings
	always @(posedge clk_i) begin
		if (!nrst_i) begin
			ctrl    <= `CTRL_RESET;
			limit1  <= {VW{1'b1}};
			limit2  <= {VW{1'b1}};
			aout_lo <= {VW{1'b0}};
			aout_hi <= {VW{1'b1}};
		end else if (wr_i) begin
			case (addr_i)
			`REG_CTRL:    ctrl    <= wdata_i;          // [R2] [R11]
			`REG_LIMIT1:  limit1  <= wdata_i[VW-1:0];
			`REG_LIMIT2:  limit2  <= wdata_i[VW-1:0];
			`REG_AOUT_LO: aout_lo <= wdata_i[VW-1:0];
			`REG_AOUT_HI: aout_hi <= wdata_i[VW-1:0];
			default:      ctrl    <= ctrl;
			endcase
		end
	end

	// register reads, data stand one cycle later
	always @(posedge clk_i) begin
		if (!nrst_i) begin
			rdata_o <= 16'h0000;
		end else if (rd_i) begin
			case (addr_i)
			`REG_CTRL:    rdata_o <= ctrl;
			`REG_STATUS:  rdata_o <= {10'h000, ctrl[`CTRL_SHOW_MAX],
				led2_o, led1_o, setup_ok, net, trig_lvl};
			`REG_LIMIT1:  rdata_o <= {{(16-VW){1'b0}}, limit1};
			`REG_LIMIT2:  rdata_o <= {{(16-VW){1'b0}}, limit2};
			`REG_AOUT_LO: rdata_o <= {{(16-VW){1'b0}}, aout_lo};
			`REG_AOUT_HI: rdata_o <= {{(16-VW){1'b0}}, aout_hi};
			`REG_KEYS:    rdata_o <= {13'h0000, held};
			`REG_VALUE:   rdata_o <= {{(16-VW){1'b0}}, peak};
			default:      rdata_o <= 16'h0000;
			endcase
		end else begin
			rdata_o <= 16'h0000;
		end
	end

	// tare and peak memory
	always @(posedge clk_i) begin
		if (!nrst_i) begin
			tare_val <= {VW{1'b0}};
			net      <= 1'b0;
			peak     <= {VW{1'b0}};
		end else begin
			if (do_tare) begin
				tare_val <= value_i;                // [R3]
				net      <= 1'b1;
			end
			if (do_peak)
				peak <= net_val;                    // [R4]
			else if (sample_i && net_val > peak)
				peak <= net_val;
		end
	end

	// setup strap through two flops; open reads high
	always @(posedge clk_i) begin
		if (!nrst_i) begin
			setup_meta <= 1'b1;
			setup_sync <= 1'b1;
		end else begin
			setup_meta <= setup_n_i;
			setup_sync <= setup_meta;
		end
	end

	// decimal point blink timer
	always @(posedge clk_i) begin
		if (!nrst_i) begin
			blink_cnt <= 28'h0000000;
			blink     <= 1'b0;
		end else if (blink_cnt == BLINK_C[27:0] - 28'h0000001) begin
			blink_cnt <= 28'h0000000;
			blink     <= ~blink;
		end else begin
			blink_cnt <= blink_cnt + 28'h0000001;
		end
	end

	// registered outputs
	always @(posedge clk_i) begin
		if (!nrst_i) begin
			tg_byte_o     <= 8'h00;
			tg_valid_o    <= 1'b0;
			tare_o        <= 1'b0;
			peak_reset_o  <= 1'b0;
			led1_o        <= 1'b0;
			led2_o        <= 1'b0;
			relay1_o      <= 1'b0;
			relay2_o      <= 1'b0;
			net_o         <= 1'b0;
			dp_o          <= 1'b0;
			digit_blank_o <= 4'h0;
			aout_o        <= {VW{1'b0}};
			key_brief_o   <= 3'h0;
			key_long_o    <= 3'h0;
			setup_ok_o    <= 1'b0;
		end else begin
			tg_valid_o    <= sample_i;
			tg_byte_o     <= {`TG_HEADER, 3'h0, trig_lvl,
				value_i[13:12]};                    // [R1]
			tare_o        <= do_tare;
			peak_reset_o  <= do_peak;
			led1_o        <= lim1;                   // [R10]
			led2_o        <= lim2;                   // [R10]
			relay1_o      <= lim1 ^ ctrl[`CTRL_REL1_POL];   // [R11]
			relay2_o      <= lim2 ^ ctrl[`CTRL_REL2_POL];   // [R11]
			net_o         <= net;
			dp_o          <= ctrl[`CTRL_SHOW_MAX] & blink;  // [R17]
			digit_blank_o <= ctrl[`CTRL_SHOW_MAX] ? 4'h0 :
				blank_mask(net_val);                // [R18]
			aout_o        <= next_aout;
			key_brief_o   <= brief;
			key_long_o    <= long_p;
			setup_ok_o    <= setup_ok;               // [R14] [R15]
		end
	end
endmodule

// file: verif/tkc_props.sv
// concurrent checks on the trigger and key control ports
`timescale 1ns/1ps
module tkc_props (
	// clock and reset
	input wire        clk_i,
	input wire        nrst_i,
	// inputs
	input wire [3:0]  addr_i,
	input wire [15:0] wdata_i,
	input wire        wr_i,
	input wire        trig_i,
	input wire        setup_n_i,
	input wire        sample_i,
	// outputs
	input wire [7:0]  tg_byte_o,
	input wire        tg_valid_o,
	input wire        tare_o,
	input wire        peak_reset_o,
	input wire        led1_o,
	input wire        relay1_o,
	input wire        setup_ok_o
);
	// shadow of the control register
	reg [15:0] ctl;
	always @(posedge clk_i) begin
		if (!nrst_i)
			ctl <= 16'h0000;
		else if (wr_i && addr_i == 4'h0)
			ctl <= wdata_i;
	end
	default clocking @(posedge clk_i);
	endclocking
	default disable iff (!nrst_i);
	a_tg_after_sample: assert property (
		sample_i |=> tg_valid_o) else $error("no telegram");
	a_tg_header: assert property (
		tg_valid_o |-> tg_byte_o[7:3] == 5'h18) else $error("bad header");
	a_tare_needs_act: assert property (
		tare_o |-> ctl[0]) else $error("tare not selected");
	a_peak_needs_act: assert property (
		peak_reset_o |-> ctl[1]) else $error("peak not selected");
	a_both_together: assert property (
		ctl[1:0] == 2'h3 |-> tare_o == peak_reset_o)
		else $error("split action");
	a_single_pulse: assert property (
		tare_o |=> !tare_o) else $error("repeated tare");
	a_after_fall: assert property (
		(tare_o || peak_reset_o) |-> !$past(trig_i, 2))
		else $error("action before pulse end");
	a_relay_pol: assert property (
		$stable(led1_o) && $stable(ctl[2]) |-> relay1_o == (led1_o ^ ctl[2]))
		else $error("relay polarity");
	a_setup_lock: assert property (
		setup_n_i [*5] |-> !setup_ok_o) else $error("setup not locked");
	a_setup_open: assert property (
		!setup_n_i [*5] |-> setup_ok_o) else $error("setup not open");
	c_tare: cover property (tare_o && !peak_reset_o);
	c_both: cover property (tare_o && peak_reset_o);
	c_tg_trig: cover property (tg_valid_o && tg_byte_o[2]);
endmodule
bind trigger_key_control tkc_props i_tkc_props (
	.clk_i, .nrst_i, .addr_i, .wdata_i, .wr_i, .trig_i, .setup_n_i,
	.sample_i, .tg_byte_o, .tg_valid_o, .tare_o, .peak_reset_o,
	.led1_o, .relay1_o, .setup_ok_o
);

// file: verif/trig_key_src.sv
// operator model driving the trigger pin and the external keys
`timescale 1ns/1ps
module trig_key_src (
	// clock
	input  wire       clk_i,
	// pins toward the block
	output reg        trig_o,
	output reg  [2:0] key_n_o
);
	initial begin
		trig_o = 1'b0;
		key_n_o = 3'h7;
	end
	// hold the trigger high for n cycles
	task pulse(input int n);
		@(posedge clk_i);
		trig_o <= 1'b1;
		repeat (n) @(posedge clk_i);
		trig_o <= 1'b0;
	endtask
	task level(input logic v);
		@(posedge clk_i);
		trig_o <= v;
	endtask
	// ground one key for n cycles
	task press(input int k, input int n);
		@(posedge clk_i);
		key_n_o[k] <= 1'b0;
		repeat (n) @(posedge clk_i);
		key_n_o[k] <= 1'b1;
	endtask
endmodule

// file: verif/trigger_key_control_tb.sv
// self-checking bench for the trigger and key control block
`timescale 1ns/1ps
module trigger_key_control_tb;
	logic        clk_i = 1'b0;
	logic        nrst_i = 1'b0;
	logic [3:0]  addr_i = 4'h0;
	logic [15:0] wdata_i = 16'h0000;
	logic        wr_i = 1'b0;
	logic        rd_i = 1'b0;
	logic        setup_n_i = 1'b1;
	logic [13:0] value_i = 14'h0000;
	logic        sample_i = 1'b0;
	wire         trig_i;
	wire  [2:0]  key_n_i;
	wire  [15:0] rdata_o;
	wire  [7:0]  tg_byte_o;
	wire  [2:0]  key_brief_o;
	wire  [2:0]  key_long_o;
	wire         tg_valid_o, tare_o, peak_reset_o, net_o, setup_ok_o;
	wire         led1_o, led2_o, relay1_o, relay2_o, dp_o;
	wire  [3:0]  digit_blank_o;
	wire  [13:0] aout_o;
	int          err_total = 0;
	int          n_checks = 0;
	always #25 clk_i = ~clk_i;
	trig_key_src i_trig_key_src (.clk_i, .trig_o(trig_i), .key_n_o(key_n_i));
	// short counts keep every pulse within a few hundred cycles
	trigger_key_control #(.TRIG_MIN_C(10), .TRIG_MAX_C(100),
		.KEY_BRIEF_C(5), .KEY_LONG_C(50), .BLINK_C(4)
	) i_trigger_key_control (
		.clk_i, .nrst_i, .addr_i, .wdata_i, .wr_i, .rd_i, .rdata_o,
		.trig_i, .key_n_i, .setup_n_i, .value_i, .sample_i, .tg_byte_o,
		.tg_valid_o, .tare_o, .peak_reset_o, .led1_o, .led2_o, .relay1_o,
		.relay2_o, .net_o, .dp_o, .digit_blank_o, .aout_o,
		.key_brief_o, .key_long_o, .setup_ok_o
	);
	task chk(input string nm, input logic [15:0] e, input logic [15:0] g);
		n_checks++;
		if (g !== e) begin
			err_total++;
			$display("FAIL %s expected %h seen %h", nm, e, g);
		end
	endtask
	task wr(input logic [3:0] a, input logic [15:0] d);
		@(posedge clk_i);
		wr_i <= 1'b1;
		addr_i <= a;
		wdata_i <= d;
		@(posedge clk_i);
		wr_i <= 1'b0;
	endtask
	task rchk(input string nm, input logic [3:0] a, input logic [15:0] e);
		@(posedge clk_i);
		rd_i <= 1'b1;
		addr_i <= a;
		@(posedge clk_i);
		rd_i <= 1'b0;
		#1 chk(nm, e, rdata_o);
	endtask
	task smp(input logic [13:0] v);
		@(posedge clk_i);
		value_i <= v;
		sample_i <= 1'b1;
		@(posedge clk_i);
		sample_i <= 1'b0;
	endtask
	task t_lim(input logic [15:0] c, input logic [13:0] v, input logic [3:0] e);
		wr(4'h0, c);
		smp(v);
		repeat (6) @(posedge clk_i);
		#1 chk("limits", {12'h000, e},
			{12'h000, led2_o, led1_o, relay2_o, relay1_o});
	endtask
	task t_tg(input logic v);
		i_trig_key_src.level(v);
		repeat (4) @(posedge clk_i);
		smp(14'h3ABC);
		#1 chk("telegram", {9'h000, 1'b1, 5'h18, v},
			{9'h000, tg_valid_o, tg_byte_o[7:2]});
	endtask
	task t_setup(input logic v);
		@(posedge clk_i);
		setup_n_i <= v;
		repeat (6) @(posedge clk_i);
		#1 chk("setup_ok", {15'h0000, ~v}, {15'h0000, setup_ok_o});
	endtask
	task t_key(input int k, input int n, input logic [15:0] e);
		int nb, nl, bad;
		nb = 0;
		nl = 0;
		bad = 0;
		fork
			i_trig_key_src.press(k, n);
			repeat (n + 10) begin
				@(posedge clk_i);
				#1;
				if (key_long_o[k] === 1'b1 && nb == 0)
					bad = 1;
				nb += (key_brief_o[k] === 1'b1);
				nl += (key_long_o[k] === 1'b1);
			end
		join
		chk("keys", e, {4'h0, 4'(nb), 4'(nl), 4'(bad)});
	endtask
	task t_act(input logic [1:0] a, input int len, input logic [15:0] e);
		int nt, np;
		nt = 0;
		np = 0;
		// maximum display stays selected throughout
		wr(4'h0, {10'h000, 1'b1, 3'h0, a});
		fork
			i_trig_key_src.pulse(len);
			repeat (len + 20) begin
				@(posedge clk_i);
				#1;
				nt += (tare_o === 1'b1);
				np += (peak_reset_o === 1'b1);
			end
		join
		chk("actions", e, {8'(nt), 8'(np)});
	endtask
	task t_disp;
		int nd;
		nd = 0;
		wr(4'h0, 16'h0020);
		repeat (2) @(posedge clk_i);
		repeat (16) begin
			@(posedge clk_i);
			#1 nd += (dp_o === 1'b1);
		end
		chk("dp", 16'h0008, 16'(nd));
		wr(4'h0, 16'h0000);
		smp(14'h3B52);
		repeat (2) @(posedge clk_i);
		#1 chk("dp_off", 16'h0000, {15'h0000, dp_o});
		chk("blank", 16'h0008, {12'h000, digit_blank_o});
		chk("aout", 16'h0064, {2'h0, aout_o});
	endtask
	task summarize;
		if (err_total == 0 && n_checks > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask
	initial begin
		repeat (2) @(posedge clk_i);
		nrst_i <= 1'b1;
		rchk("ctrl", 4'h0, 16'h0000);
		rchk("limit2", 4'h3, 16'h3FFF);
		rchk("unmapped", 4'hA, 16'h0000);
		wr(4'hB, 16'h1234);
		wr(4'h2, 16'h0064);
		wr(4'h3, 16'h00C8);
		rchk("limit1", 4'h2, 16'h0064);
		t_lim(16'h0004, 14'h0096, 4'h4);
		t_lim(16'h0000, 14'h00FA, 4'hF);
		t_lim(16'h0008, 14'h00FA, 4'hD);
		t_tg(1'b1);
		t_tg(1'b0);
		t_setup(1'b0);
		t_setup(1'b1);
		t_key(0, 60, 16'h0110);
		t_key(1, 20, 16'h0100);
		t_key(2, 3, 16'h0000);
		t_act(2'h0, 20, 16'h0000);
		t_act(2'h1, 20, 16'h0100);
		chk("net", 16'h0001, {15'h0000, net_o});
		smp(14'h3AEE);
		t_act(2'h2, 20, 16'h0001);
		rchk("peak", 4'h7, 16'h0032);
		t_act(2'h3, 20, 16'h0101);
		t_act(2'h3, 5, 16'h0000);
		t_act(2'h3, 150, 16'h0000);
		t_disp;
		summarize;
	end
endmodule
